// ### rtl/duty_calc.v
/*
 Duty computation for both command modes, clamped to full scale.
 Assumes inputs held stable by the caller; result is registered.
*/
`timescale 1ns/10ps
`default_nettype none
`include "motor_ctl_defines.vh"

module duty_calc
(
	input  wire        clk_sys_in,
	input  wire        rst_b_in,
	input  wire        man_mode_in,
	input  wire [7:0]  in_duty_in,
	input  wire [11:0] diff_mv_in,
	input  wire [15:0] vbat_mv_in,
	output reg  [7:0]  duty_out
);

	reg [31:0] num_mv;
	reg [31:0] q;

	always @*
	begin
		num_mv = 32'h0;
		q = 32'h0;
		if (man_mode_in)
			num_mv = `DUTY_BASE_MV + ((`DUTY_MAN_GAIN_X100 * {20'h0, diff_mv_in}) / 100);
		else
			num_mv = `DUTY_BASE_MV + ((`DUTY_AUTO_SPAN_MV * (32'd255 - {24'h0, in_duty_in})) / 255);
		if (vbat_mv_in != 16'h0)
			q = (num_mv * 255) / {16'h0, vbat_mv_in};
		else
			q = 32'hff;
	end

	always @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			duty_out <= 8'h00;
		else if (q > 32'hff)
			duty_out <= `DUTY_FULL;
		else
			duty_out <= q[7:0];
	end

endmodule // duty_calc
`default_nettype wire

// ### rtl/motor_ctl_defines.vh
/*
 Constants for the brush motor PWM state and fault logic.
 Assumes inclusion by bare name from rtl/ files; definitions only.
*/
`ifndef MOTOR_CTL_DEFINES_VH
`define MOTOR_CTL_DEFINES_VH

// Oscillator clock rate in Hz
`define OSC_RATE_HZ          20000000
// Command activity timeout, in oscillator cycles
`define CMD_TIMEOUT_CYC      2048
// Current-limit window length, in oscillator cycles
`define WIN_LEN_CYC          8192
// Consecutive flagged windows that trip a shutdown
`define WIN_TRIP_COUNT       4'h8
// Disable period after first trip, in oscillator cycles
`define DISABLE_CYC          65536
// Duty arithmetic: values in millivolts, duty in 0..255 steps
`define DUTY_BASE_MV         2880
`define DUTY_AUTO_SPAN_MV    13120
`define DUTY_MAN_GAIN_X100   656
`define DUTY_FULL            8'hff
`define PWM_PERIOD_CYC       8'hff

`endif

// ### rtl/motor_pwm_state_fault_logic.v
/*
 Sleep/run/fault sequencing, command decode, PWM and current fault timers.
 Assumes analog comparators deliver synchronous digital levels and the
 supply voltage as a millivolt word; one clock stands for the oscillator.
*/
`timescale 1ns/10ps
`default_nettype none
`include "motor_ctl_defines.vh"

module motor_pwm_state_fault_logic
(
	input  wire        clk_sys_in,
	input  wire        rst_b_in,
	input  wire        duty_cmd_in,
	input  wire        res_cmd_high_in,
	input  wire        res_cmd_open_in,
	input  wire [11:0] diff_mv_in,
	input  wire [15:0] vbat_mv_in,
	input  wire        over_volt_in,
	input  wire        under_volt_in,
	input  wire        drain_sense_in,
	input  wire        trip_reference_in,
	output reg         gate_output,
	output reg         pullup_en_out,
	output reg         sink_en_out,
	output reg         filter_pull_out,
	output reg         cur_limit_out,
	output reg  [7:0]  output_duty,
	output reg  [3:0]  state_out
);

	localparam [3:0] ST_SLEEP   = 4'b0001;
	localparam [3:0] ST_RUN     = 4'b0010;
	localparam [3:0] ST_DISABLE = 4'b0100;
	localparam [3:0] ST_LATCHED = 4'b1000;

	reg  [3:0]  state_r;
	reg  [3:0]  state_nxt;
	reg         cmd_d_r;
	reg  [10:0] idle_cnt_r;
	reg  [12:0] win_cnt_r;
	reg         win_flag_r;
	reg  [3:0]  flag_run_r;
	reg         retry_r;
	reg  [15:0] dis_cnt_r;
	reg  [7:0]  pwm_cnt_r;
	reg  [7:0]  hi_cnt_r;
	reg  [7:0]  in_duty_r;
	wire [7:0]  duty_w;
	wire        man_mode;
	wire        supply_bad;
	wire        idle_done;
	wire        win_end;
	wire        trip;
	wire        cur_lim;

	assign man_mode   = res_cmd_high_in;
	assign supply_bad = over_volt_in | under_volt_in;
	assign idle_done  = (idle_cnt_r == 11'h7ff);
	assign win_end    = (win_cnt_r == 13'h1fff);
	// current limit only while gate high
	assign cur_lim    = gate_output & (drain_sense_in > trip_reference_in);
	assign trip       = win_end & (win_flag_r | cur_lim) & (flag_run_r == 4'h7);

	duty_calc u_duty
	(
		.clk_sys_in  (clk_sys_in),
		.rst_b_in    (rst_b_in),
		.man_mode_in (man_mode),
		.in_duty_in  (in_duty_r),
		.diff_mv_in  (diff_mv_in),
		.vbat_mv_in  (vbat_mv_in),
		.duty_out    (duty_w)
	);

	////////////////////////////////////////////////////////////////////////////
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_SLEEP:
			begin
				if (!under_volt_in && ((man_mode && !res_cmd_open_in) ||
					(!man_mode && cmd_d_r && !duty_cmd_in)))
					state_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				if (under_volt_in || (man_mode && res_cmd_open_in) ||
					(!man_mode && idle_done))
					state_nxt = ST_SLEEP;
				else if (trip)
					state_nxt = retry_r ? ST_LATCHED : ST_DISABLE;
			end
			ST_DISABLE:
			begin
				if (dis_cnt_r == 16'hffff)
					state_nxt = ST_RUN;
			end
			ST_LATCHED:
			begin
				if (under_volt_in || (man_mode ? res_cmd_open_in : idle_done))
					state_nxt = ST_SLEEP;
			end
			default:
				state_nxt = ST_SLEEP;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_r    <= ST_SLEEP;
			cmd_d_r    <= 1'b1;
			idle_cnt_r <= 11'h000;
			win_cnt_r  <= 13'h0000;
			win_flag_r <= 1'b0;
			flag_run_r <= 4'h0;
			retry_r    <= 1'b0;
			dis_cnt_r  <= 16'h0000;
			pwm_cnt_r  <= 8'h00;
			hi_cnt_r   <= 8'h00;
			in_duty_r  <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			cmd_d_r <= duty_cmd_in;
			if (state_nxt == ST_SLEEP)
			begin
				idle_cnt_r <= 11'h000;
				win_cnt_r  <= 13'h0000;
				win_flag_r <= 1'b0;
				flag_run_r <= 4'h0;
				retry_r    <= 1'b0;
				dis_cnt_r  <= 16'h0000;
			end
			else
			begin
				if (cmd_d_r != duty_cmd_in)
					idle_cnt_r <= 11'h000;
				else if (!idle_done)
					idle_cnt_r <= idle_cnt_r + 11'h001;
				if (state_r == ST_DISABLE)
					dis_cnt_r <= dis_cnt_r + 16'h0001;
				else
					dis_cnt_r <= 16'h0000;
				if (state_r == ST_RUN)
				begin
					win_cnt_r <= win_cnt_r + 13'h0001;
					if (win_end)
					begin
						win_flag_r <= 1'b0;
						if (trip)
						begin
							flag_run_r <= 4'h0;
							retry_r    <= 1'b1;
						end
						else if (win_flag_r | cur_lim)
							flag_run_r <= flag_run_r + 4'h1;
						else
						begin
							flag_run_r <= 4'h0;
							retry_r    <= 1'b0;
						end
					end
					else if (cur_lim)
						win_flag_r <= 1'b1;
				end
				else
				begin
					win_cnt_r  <= 13'h0000;
					win_flag_r <= 1'b0;
				end
			end
			// inverted command: measure high time per PWM frame
			pwm_cnt_r <= pwm_cnt_r + 8'h01;
			if (pwm_cnt_r == `PWM_PERIOD_CYC)
			begin
				in_duty_r <= hi_cnt_r;
				hi_cnt_r  <= duty_cmd_in ? 8'h01 : 8'h00;
			end
			else if (duty_cmd_in && hi_cnt_r != 8'hff)
				hi_cnt_r <= hi_cnt_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			gate_output     <= 1'b0;
			pullup_en_out   <= 1'b0;
			sink_en_out     <= 1'b0;
			filter_pull_out <= 1'b1;
			cur_limit_out   <= 1'b0;
			output_duty     <= 8'h00;
			state_out       <= ST_SLEEP;
		end
		else
		begin
			state_out     <= state_r;
			output_duty   <= duty_w;
			cur_limit_out <= cur_lim;
			// pull-up only awake in duty mode
			pullup_en_out <= !man_mode && (state_r != ST_SLEEP);
			sink_en_out   <= man_mode && (state_r == ST_RUN);
			filter_pull_out <= (state_r != ST_RUN) || over_volt_in || cur_lim;
			// gate off unless running in range; full means high
			if (state_r != ST_RUN || supply_bad)
				gate_output <= 1'b0;
			else
				gate_output <= (duty_w == `DUTY_FULL) || (pwm_cnt_r < duty_w);
		end
	end

endmodule // motor_pwm_state_fault_logic
`default_nettype wire

// ### testbench/cmd_src_model.sv
/* Speed command source on the duty pin, open collector.
 Assumes one clock standing for the device oscillator. */
`timescale 1ns/10ps
`default_nettype none
module cmd_src_model
(
	input wire logic       clk_sys_in,
	input wire logic       src_en_in,
	input wire logic [7:0] hi_cyc_in,
	input wire logic       sink_en_in,
	output var logic       duty_pin_out
);
	logic [7:0] cnt_r = 8'h00;
	// 100 kHz frame of 200 cycles
	always @(posedge clk_sys_in)
		cnt_r <= (cnt_r == 8'hc7) ? 8'h00 : cnt_r + 8'h01;
	// low part first; a released pin reads high
	always @*
		duty_pin_out = !(sink_en_in || (src_en_in && cnt_r < 8'hc8 - hi_cyc_in));
endmodule // cmd_src_model
`default_nettype wire

// ### testbench/motor_pwm_state_fault_logic_bench.sv
/* Self-checking bench for the motor state and fault logic.
 Assumes the source model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module motor_pwm_state_fault_logic_bench;
	logic clk_sys_in = 1'b0, rst_b_in = 1'b0, res_cmd_high_in = 1'b0, res_cmd_open_in = 1'b0;
	logic over_volt_in = 1'b0, under_volt_in = 1'b0, drain_sense_in = 1'b0;
	logic trip_reference_in = 1'b0, src_en = 1'b0;
	logic [7:0] hi_cyc = 8'h08;
	logic [11:0] diff_mv_in = 12'h000;
	logic [15:0] vbat_mv_in = 16'h3a98;
	logic [19:0] q[$], e;
	wire duty_cmd_in, gate_output, pullup_en_out, sink_en_out, filter_pull_out, cur_limit_out;
	wire [7:0] output_duty;
	wire [3:0] state_out;
	int err_count = 0, compares = 0;
	motor_pwm_state_fault_logic DUT (.*);
	cmd_src_model u_src (.clk_sys_in(clk_sys_in), .src_en_in(src_en), .hi_cyc_in(hi_cyc),
		.sink_en_in(sink_en_out), .duty_pin_out(duty_cmd_in));
	always #25 clk_sys_in = ~clk_sys_in;
	task automatic final_report();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic ex(input logic [3:0] s, input logic [15:0] v);
		q.push_back({s, v});
	endtask
	task automatic wait_st(input logic [3:0] s, input int n);
		for (int i = 0; i < n && state_out !== s; i++)
			@(negedge clk_sys_in);
		ex(4'h0, {12'h000, s});
		@(posedge clk_sys_in);
	endtask
	function automatic logic [15:0] dexp(input int mv);
		int d;
		d = mv * 255 / vbat_mv_in;
		return (d > 255) ? 16'h00ff : d[15:0];
	endfunction
	// Duty margin covers the beat of the 200-cycle source against the frame
	always @(negedge clk_sys_in)
		while (q.size() > 0)
		begin
			e = q.pop_front();
			case (e[19:16])
				4'h0: check({12'h000, state_out}, e[15:0]);
				4'h2: check({15'h0000, pullup_en_out}, e[15:0]);
				4'h3: check({15'h0000, sink_en_out}, e[15:0]);
				4'h4: check({15'h0000, cur_limit_out}, e[15:0]);
				default: check((output_duty + 16'h0038 < e[15:0] || output_duty > e[15:0] + 16'h0038)
					? {8'h00, output_duty} : e[15:0], e[15:0]);
			endcase
		end
	initial
	begin
		#(95000 * 50);
		err_count++;
		final_report();
	end
	initial
	begin
		void'($urandom(32'h256a0e7c));
		cyc(3);
		rst_b_in <= 1'b1;
		vbat_mv_in <= 16'h3a98 + 16'($urandom % 1001);
		wait_st(4'h1, 2);
		src_en <= 1'b1;
		wait_st(4'h2, 400);
		cyc(2000);
		ex(4'h2, 16'h0001);
		ex(4'h5, dexp(2880 + 13120 * 192 / 200));
		hi_cyc <= 8'hb4;
		cyc(2000);
		ex(4'h5, dexp(2880 + 13120 * 20 / 200));
		@(posedge duty_cmd_in);
		src_en <= 1'b0;
		cyc(2040);
		ex(4'h0, 16'h0002);
		wait_st(4'h1, 30);
		res_cmd_high_in <= 1'b1;
		diff_mv_in <= 12'($urandom % 2201);
		wait_st(4'h2, 50);
		cyc(600);
		ex(4'h3, 16'h0001);
		ex(4'h2, 16'h0000);
		ex(4'h5, dexp(2880 + 656 * diff_mv_in / 100));
		over_volt_in <= 1'b1;
		cyc(5);
		ex(4'h0, 16'h0002);
		over_volt_in <= 1'b0;
		res_cmd_open_in <= 1'b1;
		wait_st(4'h1, 50);
		vbat_mv_in <= 16'h1f40;
		diff_mv_in <= 12'h898;
		res_cmd_open_in <= 1'b0;
		wait_st(4'h2, 50);
		drain_sense_in <= 1'b1;
		cyc(600);
		ex(4'h5, 16'h00ff);
		ex(4'h4, 16'h0001);
		cyc(64000);
		ex(4'h0, 16'h0002);
		wait_st(4'h4, 10000);
		cyc(2);
		final_report();
	end
endmodule // motor_pwm_state_fault_logic_bench
`default_nettype wire

// ### testbench/motor_pwm_state_fault_logic_sva.sv
/* Checker for the motor state and fault logic.
 Assumes a bind to the top module; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module motor_chk
(
	input wire logic       clk_sys_in,
	input wire logic       rst_b_in,
	input wire logic       duty_cmd_in,
	input wire logic       res_cmd_high_in,
	input wire logic       under_volt_in,
	input wire logic       over_volt_in,
	input wire logic       drain_sense_in,
	input wire logic       gate_output,
	input wire logic       pullup_en_out,
	input wire logic       sink_en_out,
	input wire logic       filter_pull_out,
	input wire logic       cur_limit_out,
	input wire logic [3:0] state_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	wake_fall_a: assert property (state_out == 4'h1 && $fell(duty_cmd_in) && !res_cmd_high_in
		&& !under_volt_in |-> ##2 state_out == 4'h2) else $error("wake missed");
	sleep_pull_a: assert property (state_out == 4'h1 [*2] |-> !pullup_en_out)
		else $error("pull-up in sleep");
	sleep_sink_a: assert property (state_out == 4'h1 [*2] |-> !sink_en_out)
		else $error("sinks in sleep");
	sleep_gate_a: assert property (state_out == 4'h1 [*2] |-> !gate_output && filter_pull_out)
		else $error("gate in sleep");
	ov_gate_a: assert property (over_volt_in [*3] |-> !gate_output && filter_pull_out)
		else $error("gate in over-voltage");
	limit_cause_a: assert property (cur_limit_out |-> $past(gate_output) && $past(drain_sense_in))
		else $error("limit without cause");
	disable_off_a: assert property (state_out == 4'h4 [*2] |-> !gate_output && filter_pull_out)
		else $error("gate while disabled");
	fault_off_a: assert property (state_out == 4'h8 [*2] |-> !gate_output && filter_pull_out)
		else $error("gate in fault");
endmodule // motor_chk
bind motor_pwm_state_fault_logic motor_chk u_chk (.*);
`default_nettype wire
